// File: include/spar_pkg.sv
package spar_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS   = 8'h0c;
   localparam logic [7:0] IDX_RECEIVE_STATUS_CONTROL = 8'h18;
   localparam logic [7:0] IDX_TRANSMIT_BUFFER        = 8'h19;
   localparam logic [7:0] IDX_RECEIVE_BUFFER         = 8'h1a;
   localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8c;
   localparam logic [7:0] IDX_TRANSMIT_STATUS_CONTROL = 8'h98;
   localparam logic [7:0] IDX_BAUD_DIVISOR           = 8'h99;

   // reset values
   localparam logic [7:0] RST_RECEIVE_STATUS_CONTROL  = 8'h00;
   localparam logic [7:0] RST_TRANSMIT_BUFFER         = 8'h00;
   localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLES  = 8'h00;
   localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h02;
   localparam logic [7:0] RST_BAUD_DIVISOR            = 8'h00;

   // bit positions, flag and enable registers
   localparam int BIT_RECEIVE_READY = 5;
   // receive status/control
   localparam int BIT_SERIAL_PORT_ENABLE = 7;
   localparam int BIT_NINE_BIT_RECEIVE   = 6;
   localparam int BIT_SINGLE_RECEIVE     = 5;
   localparam int BIT_CONT_RECEIVE       = 4;
   localparam int BIT_FRAMING_ERROR      = 2;
   localparam int BIT_OVERRUN_ERROR      = 1;
   localparam int BIT_RECEIVED_NINTH     = 0;
   // transmit status/control
   localparam int BIT_CLOCK_SOURCE       = 7;
   localparam int BIT_TRANSMIT_ENABLE    = 5;
   localparam int BIT_SYNC_SELECT        = 4;
   localparam int BIT_HIGH_RATE          = 2;
   localparam int BIT_SHIFTER_EMPTY      = 1;

   // oversampling: sixteen ticks per bit, votes on ticks 6, 7 and 8
   localparam logic [3:0] OVS_LAST     = 4'hf;
   localparam logic [3:0] VOTE_FIRST   = 4'h6;
   localparam logic [3:0] VOTE_LAST    = 4'h8;
   localparam logic [1:0] LOW_RATE_DIV = 2'h3;

   typedef enum logic [1:0] {
      SPAR_IDLE,
      SPAR_START,
      SPAR_DATA,
      SPAR_STOP
   } spar_state_t;

   typedef struct packed {
      logic [7:0] data;
      logic       ninth;
      logic       framing_error;
   } spar_entry_t;

endpackage : spar_pkg

// File: core/spar_receiver.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
module spar_receiver
   import spar_pkg::*;
#(
   parameter int FIFO_DEPTH = 2,
   parameter int ADDR_W     = 12
) (
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              serial_data_line_in,
   output logic                   serial_data_line_out,
   output logic                   serial_data_line_oe,
   output logic                   shift_clock_line_out,
   output logic                   shift_clock_line_oe,
   output logic                   serial_pins_selected,
   input  wire logic              transmit_active,
   input  wire logic              transmit_data,
   output logic                   transmit_inhibit,
   output logic                   receive_irq_request
);

   localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
   localparam logic [CNT_W-1:0] FIFO_FULL = CNT_W'(FIFO_DEPTH);

   function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
      idx_hit = (a == ADDR_W'({idx, 2'b00}));
   endfunction : idx_hit

   ////////////////////////////////////////////////////////////////////////////
   // register state

   logic [7:0]      receive_status_control_ctl;
   logic [7:0]      transmit_status_control_ctl;
   logic [7:0]      tx_buffer;
   logic [7:0]      irq_enables;
   logic [7:0]      baud_divisor;
   logic [7:0]      next_receive_status_control_ctl;
   logic [7:0]      next_transmit_status_control_ctl;
   logic [7:0]      next_tx_buffer;
   logic [7:0]      next_irq_enables;
   logic [7:0]      next_baud_divisor;
   logic [31:0]     next_prdata;
   logic            read_saw_data;
   logic            next_read_saw_data;
   logic            setup;
   logic            access;
   logic            mapped;
   logic            pop;

   spar_entry_t                 fifo_mem [FIFO_DEPTH];
   logic [PTR_W-1:0]            wr_ptr;
   logic [PTR_W-1:0]            rd_ptr;
   logic [CNT_W-1:0]            count;
   logic [PTR_W-1:0]            next_wr_ptr;
   logic [PTR_W-1:0]            next_rd_ptr;
   logic [CNT_W-1:0]            next_count;
   logic                        push;
   spar_entry_t                 push_entry;
   spar_entry_t                 head;
   logic                        overrun_error;
   logic                        next_overrun_error;
   logic                        receive_ready_flag;

   logic serial_port_enable;
   logic continuous_receive_enable;
   logic single_receive_enable;
   logic rx9;
   logic sync_mode;
   logic clock_source_select;
   logic rx_on;
   logic brg_run;

   assign serial_port_enable      = receive_status_control_ctl[BIT_SERIAL_PORT_ENABLE];
   assign continuous_receive_enable      = receive_status_control_ctl[BIT_CONT_RECEIVE];
   assign single_receive_enable      = receive_status_control_ctl[BIT_SINGLE_RECEIVE];
   assign rx9       = receive_status_control_ctl[BIT_NINE_BIT_RECEIVE];
   assign sync_mode = transmit_status_control_ctl[BIT_SYNC_SELECT];
   assign clock_source_select      = transmit_status_control_ctl[BIT_CLOCK_SOURCE];
   assign rx_on     = serial_port_enable & continuous_receive_enable & ~sync_mode;
   assign brg_run   = serial_port_enable & (continuous_receive_enable | single_receive_enable | transmit_status_control_ctl[BIT_TRANSMIT_ENABLE]);

   ////////////////////////////////////////////////////////////////////////////
   // apb slave

   assign setup   = psel & ~penable;
   assign access  = psel & penable;
   assign pready  = access;
   assign mapped  = idx_hit(paddr, IDX_PERIPHERAL_IRQ_FLAGS)
                  | idx_hit(paddr, IDX_RECEIVE_STATUS_CONTROL)
                  | idx_hit(paddr, IDX_TRANSMIT_BUFFER)
                  | idx_hit(paddr, IDX_RECEIVE_BUFFER)
                  | idx_hit(paddr, IDX_PERIPHERAL_IRQ_ENABLES)
                  | idx_hit(paddr, IDX_TRANSMIT_STATUS_CONTROL)
                  | idx_hit(paddr, IDX_BAUD_DIVISOR);
   assign pslverr = access & ~mapped;
   assign pop     = access & ~pwrite & read_saw_data & idx_hit(paddr, IDX_RECEIVE_BUFFER);
   assign head    = fifo_mem[rd_ptr];

   assign receive_ready_flag  = (count != '0);
   assign receive_irq_request = receive_ready_flag & irq_enables[BIT_RECEIVE_READY];

   always_comb begin
      next_receive_status_control_ctl     = receive_status_control_ctl;
      next_transmit_status_control_ctl     = transmit_status_control_ctl;
      next_tx_buffer     = tx_buffer;
      next_irq_enables   = irq_enables;
      next_baud_divisor  = baud_divisor;
      next_prdata        = prdata;
      next_read_saw_data = read_saw_data;
      if (setup) begin
         next_prdata        = 32'h0000_0000;
         next_read_saw_data = receive_ready_flag;
         if (idx_hit(paddr, IDX_PERIPHERAL_IRQ_FLAGS)) begin
            next_prdata[BIT_RECEIVE_READY] = receive_ready_flag;
         end
         if (idx_hit(paddr, IDX_RECEIVE_STATUS_CONTROL)) begin
            next_prdata[7:3] = {receive_status_control_ctl[7:4], 1'b0};
            next_prdata[BIT_FRAMING_ERROR]  = receive_ready_flag & head.framing_error;
            next_prdata[BIT_OVERRUN_ERROR]  = overrun_error;
            next_prdata[BIT_RECEIVED_NINTH] = receive_ready_flag & head.ninth;
         end
         if (idx_hit(paddr, IDX_TRANSMIT_BUFFER)) begin
            next_prdata[7:0] = tx_buffer;
         end
         if (idx_hit(paddr, IDX_RECEIVE_BUFFER)) begin
            next_prdata[7:0] = receive_ready_flag ? head.data : 8'h00;
         end
         if (idx_hit(paddr, IDX_PERIPHERAL_IRQ_ENABLES)) begin
            next_prdata[7:0] = irq_enables;
         end
         if (idx_hit(paddr, IDX_TRANSMIT_STATUS_CONTROL)) begin
            next_prdata[7:0] = {transmit_status_control_ctl[7:4], 1'b0, transmit_status_control_ctl[2], ~transmit_active,
                                transmit_status_control_ctl[0]};
         end
         if (idx_hit(paddr, IDX_BAUD_DIVISOR)) begin
            next_prdata[7:0] = baud_divisor;
         end
      end
      if (access & pwrite) begin
         if (idx_hit(paddr, IDX_RECEIVE_STATUS_CONTROL)) begin
            next_receive_status_control_ctl = {pwdata[7:4], 4'h0};
         end
         if (idx_hit(paddr, IDX_TRANSMIT_BUFFER)) begin
            next_tx_buffer = pwdata[7:0];
         end
         if (idx_hit(paddr, IDX_PERIPHERAL_IRQ_ENABLES)) begin
            next_irq_enables = pwdata[7:0];
         end
         if (idx_hit(paddr, IDX_TRANSMIT_STATUS_CONTROL)) begin
            next_transmit_status_control_ctl = {pwdata[7:4], 1'b0, pwdata[2], 1'b0, pwdata[0]};
         end
         if (idx_hit(paddr, IDX_BAUD_DIVISOR)) begin
            next_baud_divisor = pwdata[7:0];
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         receive_status_control_ctl     <= RST_RECEIVE_STATUS_CONTROL;
         transmit_status_control_ctl     <= RST_TRANSMIT_STATUS_CONTROL & 8'hfd;
         tx_buffer     <= RST_TRANSMIT_BUFFER;
         irq_enables   <= RST_PERIPHERAL_IRQ_ENABLES;
         baud_divisor  <= RST_BAUD_DIVISOR;
         prdata        <= 32'h0000_0000;
         read_saw_data <= 1'b0;
      end else begin
         receive_status_control_ctl     <= next_receive_status_control_ctl;
         transmit_status_control_ctl     <= next_transmit_status_control_ctl;
         tx_buffer     <= next_tx_buffer;
         irq_enables   <= next_irq_enables;
         baud_divisor  <= next_baud_divisor;
         prdata        <= next_prdata;
         read_saw_data <= next_read_saw_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // baud generator: one tick per sixteenth of a bit

   logic [7:0] brg_cnt;
   logic [1:0] pre_cnt;
   logic [7:0] next_brg_cnt;
   logic [1:0] next_pre_cnt;
   logic       tick16;
   logic       ck_level;
   logic       next_ck_level;

   assign tick16 = brg_run & (brg_cnt == 8'h00)
                 & (transmit_status_control_ctl[BIT_HIGH_RATE] | (pre_cnt == 2'h0));

   always_comb begin
      next_brg_cnt  = brg_cnt;
      next_pre_cnt  = pre_cnt;
      next_ck_level = ck_level;
      if (!brg_run) begin
         next_brg_cnt  = baud_divisor;
         next_pre_cnt  = LOW_RATE_DIV;
         next_ck_level = 1'b0;
      end else if (brg_cnt == 8'h00) begin
         next_brg_cnt = baud_divisor;
         next_pre_cnt = pre_cnt - 2'h1;
         if (tick16) begin
            next_ck_level = ~ck_level;
         end
      end else begin
         next_brg_cnt = brg_cnt - 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         brg_cnt  <= 8'h00;
         pre_cnt  <= 2'h0;
         ck_level <= 1'b0;
      end else begin
         brg_cnt  <= next_brg_cnt;
         pre_cnt  <= next_pre_cnt;
         ck_level <= next_ck_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins and half-duplex steering

   logic receiving;

   assign receiving            = continuous_receive_enable | single_receive_enable;
   assign serial_pins_selected = serial_port_enable;
   assign shift_clock_line_oe  = serial_port_enable & sync_mode & clock_source_select;
   assign shift_clock_line_out = ck_level;
   assign transmit_inhibit     = serial_port_enable & sync_mode & receiving;
   assign serial_data_line_oe  = serial_port_enable & sync_mode & transmit_active & ~receiving;
   assign serial_data_line_out = transmit_data;

   ////////////////////////////////////////////////////////////////////////////
   // receive state machine

   spar_state_t state;
   spar_state_t next_state;
   logic [3:0]  phase;
   logic [3:0]  next_phase;
   logic [3:0]  bit_idx;
   logic [3:0]  next_bit_idx;
   logic [2:0]  votes;
   logic [2:0]  next_votes;
   logic [8:0]  receive_shift_register;
   logic [8:0]  next_receive_shift_register;
   logic        line_prev;
   logic        vote;
   logic        bit_done;

   assign vote     = (votes[0] & votes[1]) | (votes[0] & votes[2])
                   | (votes[1] & votes[2]);
   assign bit_done = tick16 & (phase == OVS_LAST);

   always_comb begin
      next_state                  = state;
      next_phase                  = phase;
      next_bit_idx                = bit_idx;
      next_votes                  = votes;
      next_receive_shift_register = receive_shift_register;
      next_overrun_error          = overrun_error;
      push                        = 1'b0;
      push_entry                  = '0;
      if (tick16 && phase >= VOTE_FIRST && phase <= VOTE_LAST) begin
         next_votes = {votes[1:0], serial_data_line_in};
      end
      if (tick16) begin
         next_phase = phase + 4'h1;
      end
      case (state)
         SPAR_IDLE: begin
            next_phase = 4'h0;
            if (line_prev && !serial_data_line_in) begin
               next_state = SPAR_START;
            end
         end
         SPAR_START: begin
            if (bit_done) begin
               next_bit_idx = 4'h0;
               next_state   = vote ? SPAR_IDLE : SPAR_DATA;
            end
         end
         SPAR_DATA: begin
            if (bit_done) begin
               next_receive_shift_register = {vote, receive_shift_register[8:1]};
               next_bit_idx = bit_idx + 4'h1;
               if (bit_idx == (rx9 ? 4'h8 : 4'h7)) begin
                  next_state = SPAR_STOP;
               end
            end
         end
         SPAR_STOP: begin
            if (bit_done) begin
               next_state       = SPAR_IDLE;
               push_entry.data  = rx9 ? receive_shift_register[7:0]
                                      : receive_shift_register[8:1];
               push_entry.ninth = rx9 & receive_shift_register[8];
               push_entry.framing_error  = ~vote;
               if (count == FIFO_FULL) begin
                  next_overrun_error = 1'b1;
               end else if (!overrun_error) begin
                  push = 1'b1;
               end
            end
         end
         default: begin
            next_state = SPAR_IDLE;
         end
      endcase
      if (!rx_on) begin
         next_state = SPAR_IDLE;
         push       = 1'b0;
      end
      if (!continuous_receive_enable) begin
         next_overrun_error = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state                  <= SPAR_IDLE;
         phase                  <= 4'h0;
         bit_idx                <= 4'h0;
         votes                  <= 3'h7;
         receive_shift_register <= 9'h000;
         line_prev              <= 1'b1;
         overrun_error          <= 1'b0;
      end else begin
         state                  <= next_state;
         phase                  <= next_phase;
         bit_idx                <= next_bit_idx;
         votes                  <= next_votes;
         receive_shift_register <= next_receive_shift_register;
         line_prev              <= serial_data_line_in;
         overrun_error          <= next_overrun_error;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive fifo

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count  = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wr_ptr + PTR_W'(1);
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr + PTR_W'(1);
      end
      if (push && !pop) begin
         next_count = count + CNT_W'(1);
      end else if (pop && !push) begin
         next_count = count - CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_slot
      always_ff @(posedge core_clk or negedge nrst) begin
         if (!nrst) begin
            fifo_mem[i] <= '0;
         end else if (push && wr_ptr == PTR_W'(i)) begin
            fifo_mem[i] <= push_entry;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   AST_IRQ_NEEDS_ENABLE: assert property (@(posedge core_clk) disable iff (!nrst)
      receive_irq_request == (irq_enables[BIT_RECEIVE_READY] && count != '0))
      else $error("irq does not follow enable and data");

   AST_FLAG_AFTER_PUSH: assert property (@(posedge core_clk) disable iff (!nrst)
      push |=> receive_ready_flag)
      else $error("ready flag not set after word stored");

   AST_OVERRUN_ON_FULL: assert property (@(posedge core_clk) disable iff (!nrst)
      (state == SPAR_STOP && bit_done && rx_on && count == FIFO_FULL && !pop)
      |=> overrun_error && count == FIFO_FULL)
      else $error("overrun not flagged on full fifo");

   AST_NO_PUSH_OVERRUN: assert property (@(posedge core_clk) disable iff (!nrst)
      overrun_error |-> !push)
      else $error("word stored while overrun set");

   AST_OVERRUN_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
      (overrun_error && !continuous_receive_enable) |=> !overrun_error)
      else $error("overrun survived receive reset");

   AST_OFF_GOES_IDLE: assert property (@(posedge core_clk) disable iff (!nrst)
      !rx_on |=> state == SPAR_IDLE)
      else $error("receiver active while disabled");

   AST_FRAMING_ERROR_STORED: assert property (@(posedge core_clk) disable iff (!nrst)
      push |=> fifo_mem[$past(wr_ptr)].framing_error == $past(~vote))
      else $error("framing error not stored with word");

   AST_POP_ORDER: assert property (@(posedge core_clk) disable iff (!nrst)
      (pop && !push && count == FIFO_FULL) |=> count == FIFO_FULL - CNT_W'(1)
      && rd_ptr != $past(rd_ptr))
      else $error("fifo read did not advance");

   AST_CLOCK_MASTER: assert property (@(posedge core_clk) disable iff (!nrst)
      shift_clock_line_oe == (serial_port_enable && sync_mode && clock_source_select))
      else $error("clock line drive does not match master mode");

   AST_HALF_DUPLEX: assert property (@(posedge core_clk) disable iff (!nrst)
      (serial_port_enable && sync_mode && receiving) |-> transmit_inhibit && !serial_data_line_oe)
      else $error("data line driven while receiving");

endmodule : spar_receiver

// File: verification/spar_remote_tx.sv
`timescale 1ns/1ps
module spar_remote_tx (
   input  wire logic core_clk,
   output logic      line
);
   int bit_cycles = 16;
   initial line = 1'b1;
   ////////////////////////////////////////////////////////////
   // start low, data lsb first, one stop, then idle high
   task automatic send(input logic [8:0] w, input int n, input logic stp);
      logic [10:0] f;
      f = (n == 9) ? {stp, w, 1'b0} : {1'b1, stp, w[7:0], 1'b0};
      for (int i = 0; i < n + 2; i++) begin
         line <= f[i];
         repeat (bit_cycles) @(posedge core_clk);
      end
      line <= 1'b1;
      repeat (12) @(posedge core_clk);
   endtask : send
endmodule : spar_remote_tx

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
   import spar_pkg::*;
   logic        core_clk = 1'b0;
   logic        nrst     = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0;
   logic        tx_act   = 1'b0;
   logic        tx_dat   = 1'b0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, rx, dout, doe, ckout, ckoe, pins, inh, irq;
   int          num_errors   = 0;
   int          total_checks = 0;
   int          cycles       = 0;
   always #10 core_clk = ~core_clk;
   spar_receiver dut_u (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_data_line_in(rx), .serial_data_line_out(dout),
      .serial_data_line_oe(doe), .shift_clock_line_out(ckout), .shift_clock_line_oe(ckoe),
      .serial_pins_selected(pins), .transmit_active(tx_act), .transmit_data(tx_dat),
      .transmit_inhibit(inh), .receive_irq_request(irq));
   spar_remote_tx remote_u (.core_clk(core_clk), .line(rx));
   ////////////////////////////////////////////////////////////
   task automatic test_done();
      if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb
   task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h00);
      check(nm, rd, exp);
   endtask : rdc
   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdc("flags", IDX_PERIPHERAL_IRQ_FLAGS, 32'h00);
      rdc("receive_status_control", IDX_RECEIVE_STATUS_CONTROL, 32'h00);
      rdc("rxbuf", IDX_RECEIVE_BUFFER, 32'h00);
      rdc("enables", IDX_PERIPHERAL_IRQ_ENABLES, 32'h00);
      rdc("transmit_status_control", IDX_TRANSMIT_STATUS_CONTROL, 32'h02);
      rdc("baud", IDX_BAUD_DIVISOR, 32'h00);
      apb(1'b1, IDX_TRANSMIT_BUFFER, 8'hc3);
      rdc("txbuf", IDX_TRANSMIT_BUFFER, 32'hc3);
      rdc("unmapped", 8'h01, 32'h00);
      check("slverr", err, 1'b1);
   endtask : t_reset
   task automatic t_setup();
      apb(1'b1, IDX_BAUD_DIVISOR, 8'h00);
      apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'h04);
      apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'hc0);
      apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'hd0);
      check("pins", pins, 1'b1);
   endtask : t_setup
   task automatic t_rx();
      remote_u.send(9'h1a5, 9, 1'b1);
      rdc("ready", IDX_PERIPHERAL_IRQ_FLAGS, 32'h20);
      check("irq masked", irq, 1'b0);
      apb(1'b1, IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
      rdc("flag ro", IDX_PERIPHERAL_IRQ_FLAGS, 32'h20);
      apb(1'b1, IDX_PERIPHERAL_IRQ_ENABLES, 8'h20);
      check("irq on", irq, 1'b1);
      remote_u.send(9'h03c, 9, 1'b0);
      rdc("st1", IDX_RECEIVE_STATUS_CONTROL, 32'hd1);
      rdc("w1", IDX_RECEIVE_BUFFER, 32'ha5);
      rdc("st2", IDX_RECEIVE_STATUS_CONTROL, 32'hd4);
      check("irq held", irq, 1'b1);
      rdc("w2", IDX_RECEIVE_BUFFER, 32'h3c);
      rdc("flag clr", IDX_PERIPHERAL_IRQ_FLAGS, 32'h00);
   endtask : t_rx
   task automatic t_overrun();
      apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'h90);
      remote_u.send(9'h011, 8, 1'b1);
      remote_u.send(9'h022, 8, 1'b1);
      remote_u.send(9'h033, 8, 1'b1);
      rdc("overrun_error", IDX_RECEIVE_STATUS_CONTROL, 32'h92);
      rdc("o1", IDX_RECEIVE_BUFFER, 32'h11);
      rdc("o2", IDX_RECEIVE_BUFFER, 32'h22);
      remote_u.send(9'h044, 8, 1'b1);
      rdc("blocked", IDX_PERIPHERAL_IRQ_FLAGS, 32'h00);
      apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'h80);
      remote_u.send(9'h055, 8, 1'b1);
      rdc("continuous_receive_enable off", IDX_RECEIVE_STATUS_CONTROL, 32'h80);
      rdc("no rx", IDX_PERIPHERAL_IRQ_FLAGS, 32'h00);
      apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'h90);
      remote_u.send(9'h066, 8, 1'b1);
      rdc("resumed", IDX_RECEIVE_BUFFER, 32'h66);
   endtask : t_overrun
   task automatic t_slow();
      apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'h00);
      remote_u.bit_cycles = 64;
      remote_u.send(9'h05a, 8, 1'b1);
      remote_u.bit_cycles = 16;
      apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'h04);
      rdc("slow st", IDX_RECEIVE_STATUS_CONTROL, 32'h90);
      rdc("slow", IDX_RECEIVE_BUFFER, 32'h5a);
   endtask : t_slow
   task automatic t_sync();
      logic ck0;
      apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'h94);
      check("ck oe", ckoe, 1'b1);
      ck0 = ckout;
      @(posedge core_clk);
      check("ck toggles", ckout, !ck0);
      remote_u.send(9'h077, 8, 1'b1);
      rdc("sync no rx", IDX_PERIPHERAL_IRQ_FLAGS, 32'h00);
      tx_act <= 1'b1;
      tx_dat <= 1'b1;
      @(posedge core_clk);
      check("inhibit", inh, 1'b1);
      check("dt rx", doe, 1'b0);
      rdc("busy", IDX_TRANSMIT_STATUS_CONTROL, 32'h94);
      apb(1'b1, IDX_RECEIVE_STATUS_CONTROL, 8'h80);
      check("dt tx", doe, 1'b1);
      check("no inhibit", inh, 1'b0);
      check("dt level", dout, 1'b1);
      apb(1'b1, IDX_TRANSMIT_STATUS_CONTROL, 8'h14);
      check("ck slave", ckoe, 1'b0);
   endtask : t_sync
   ////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         test_done();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      t_reset();
      t_setup();
      t_rx();
      t_overrun();
      t_slow();
      t_sync();
      test_done();
   end
endmodule : tb
